// *** rtl/icsv_pkg.sv ***
// Package for the serial interconnect connection service of the drive side.
// Assumes a single 10 MHz clock and synchronous active-high reset.
package icsv_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned FIFO_DEPTH = 8;
    // Connect, listen and receive responses
    localparam logic [2:0] RESP_GOOD = 3'h0;
    localparam logic [2:0] RESP_PORT_IN_USE = 3'h1;
    localparam logic [2:0] RESP_NO_PHYS = 3'h2;
    localparam logic [2:0] RESP_NOT_ALLOWED = 3'h3;
    localparam logic [2:0] RESP_INVALID_CONN = 3'h4;
    localparam logic [2:0] RESP_RECV_PENDING = 3'h5;
    // Disconnect reasons
    localparam logic [1:0] CLOSE_REQUESTED = 2'h0;
    localparam logic [1:0] CLOSE_SENSE_LOST = 2'h1;
    localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
    typedef enum logic [1:0] {ICSV_IDLE, ICSV_CONNECTED, ICSV_FLUSH} icsv_state_t;
endpackage

// *** rtl/icsv_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
module icsv_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic flush_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_r != DEPTH[AW:0]);
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rd_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i || flush_i) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// *** rtl/icsv_port.sv ***
// Drive-side serial interconnect port: connect/listen, send, receive, disconnect, reset.
// Assumes the transport port and the link character stream are synchronous to clk_i.
// Notes on behaviour
// - An active open is made by a connect request on the interconnect port.
// - A passive wait is made by a listen request on the interconnect port.
// - Once established, a connected indication goes to the transport port.
// - Serial connections are established with no exchange with the peer.
// - While presence-sense is asserted, a connection is considered present.
// - Connected indication rises at once after a good connect or listen.
// - With presence-sense deasserted, the connect or listen attempt fails.
// - A sense output reports whether the peer presence line is asserted.
// - Send completion means characters were accepted, not yet transmitted.
// - Receive never places more characters than the requested maximum.
// - After placing characters, a received indication reports their count.
// - Disconnect first transmits all accepted characters, then closes; if sense drops meanwhile, the queued characters are dropped.
// - After disconnected, no further received characters are delivered.
// - Closing is local, with no exchange with the peer.
// - An asserted reset line yields a reset-received indication.
// - Any signal on the reset line counts as a reset-received indication.
// - Earlier send data is transmitted before any of a later buffer.
// - A second receive before the received indication gets receive-pending.
module icsv_port
    import icsv_pkg::*;
#(
    parameter int unsigned DATA_WIDTH = icsv_pkg::DATA_W,
    parameter int unsigned FIFO_DEPTH = icsv_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,

    // Peer pins
    input wire logic sense_i,
    input wire logic peer_reset_i,

    // Connection requests
    input wire logic connect_req_i,
    input wire logic listen_req_i,
    input wire logic disconnect_req_i,
    output logic conn_resp_valid_o,
    output logic [2:0] conn_resp_o,
    output logic connected_o,
    output logic connected_ind_o,
    output logic disconnected_ind_o,
    output logic [1:0] close_reason_o,
    output logic sense_o,
    output logic reset_received_o,

    // Send side: characters written one per cycle
    input wire logic send_valid_i,
    output logic send_ready_o,
    input wire logic [icsv_pkg::DATA_W-1:0] send_data_i,
    output logic send_reject_o,

    // Link transmit stream
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output logic [icsv_pkg::DATA_W-1:0] tx_data_o,

    // Link receive stream
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    input wire logic [icsv_pkg::DATA_W-1:0] rx_data_i,

    // Receive requests and delivery
    input wire logic recv_req_i,
    input wire logic [icsv_pkg::CNT_W-1:0] recv_max_i,
    input wire logic recv_done_i,
    output logic recv_resp_valid_o,
    output logic [2:0] recv_resp_o,
    output logic recv_wr_o,
    output logic [icsv_pkg::DATA_W-1:0] recv_data_o,
    output logic received_ind_o,
    output logic [icsv_pkg::CNT_W-1:0] received_count_o
);
    import icsv_pkg::*;

    icsv_state_t state_r;
    icsv_state_t state_nxt;
    logic fifo_flush;
    logic fifo_in_ready;
    logic open;
    logic open_req;
    logic recv_active_r;
    logic [CNT_W-1:0] recv_max_r;
    logic [CNT_W-1:0] recv_cnt_r;
    logic peer_reset_prev_r;
    logic rx_take;
    logic recv_finish;
    logic recv_drop;
    logic recv_accept;
    logic close_now;
    logic [DATA_WIDTH-1:0] tx_fifo_data;

    assign open = (state_r != ICSV_IDLE);
    assign open_req = connect_req_i || listen_req_i;
    assign sense_o = sense_i;
    assign close_now = open && (state_nxt == ICSV_IDLE);

    // Connection state; no peer exchange on open or close
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ICSV_IDLE: begin
                if (open_req && sense_i) begin
                    state_nxt = ICSV_CONNECTED;
                end
            end
            ICSV_CONNECTED: begin
                if (!sense_i) begin
                    state_nxt = ICSV_IDLE;
                end else if (disconnect_req_i) begin
                    state_nxt = ICSV_FLUSH;
                end
            end
            ICSV_FLUSH: begin
                if (!sense_i) begin
                    state_nxt = ICSV_IDLE;
                end else if (!tx_valid_o) begin
                    state_nxt = ICSV_IDLE;
                end
            end
            default: begin
                state_nxt = ICSV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= ICSV_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Connect/listen response and indications
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            conn_resp_valid_o <= 1'b0;
        end else begin
            conn_resp_valid_o <= open_req;
        end
    end

    // Refusal reasons in priority order
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            conn_resp_o <= RESP_GOOD;
        end else if (open_req) begin
            if (open) begin
                conn_resp_o <= RESP_PORT_IN_USE;
            end else if (!sense_i) begin
                conn_resp_o <= RESP_NO_PHYS;
            end else begin
                conn_resp_o <= RESP_GOOD;
            end
        end
    end

    // No wait for the peer: sense stands for the link
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            connected_ind_o <= 1'b0;
        end else begin
            connected_ind_o <= open_req && !open && sense_i;
        end
    end

    // Follows the next state, so it rises with the indication
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            connected_o <= 1'b0;
        end else begin
            connected_o <= (state_nxt != ICSV_IDLE);
        end
    end

    // One pulse per close, asked for or forced
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            disconnected_ind_o <= 1'b0;
        end else begin
            disconnected_ind_o <= close_now;
        end
    end

    // Reason held until the next close
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            close_reason_o <= CLOSE_REQUESTED;
        end else if (close_now) begin
            close_reason_o <= sense_i ? CLOSE_REQUESTED : CLOSE_SENSE_LOST;
        end
    end

    // Send accepted only while connected and not closing
    assign send_ready_o = (state_r == ICSV_CONNECTED) && fifo_in_ready;
    // Refusal visible at once, so the transport port never waits on it
    assign send_reject_o = send_valid_i && (state_r != ICSV_CONNECTED);
    // Dropping queued data when the peer disappears: nobody is left to receive it
    assign fifo_flush = !sense_i || (state_r == ICSV_IDLE);

    // FIFO keeps earlier characters strictly ahead of later ones
    icsv_fifo #(
        .WIDTH(DATA_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .flush_i(fifo_flush),
        .in_valid_i(send_valid_i && (state_r == ICSV_CONNECTED)),
        .in_ready_o(fifo_in_ready),
        .in_data_i(send_data_i),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i),
        .out_data_o(tx_fifo_data)
    );

    assign tx_data_o = tx_fifo_data;

    // Receive path
    assign rx_take = rx_valid_i && rx_ready_o;
    // No take in the finishing cycle: that char would be placed but not counted
    assign rx_ready_o = recv_active_r && (state_r == ICSV_CONNECTED)
                        && (recv_cnt_r != recv_max_r) && !recv_finish;
    assign recv_finish = recv_active_r && (recv_cnt_r != COUNT_RESET)
                         && ((recv_cnt_r == recv_max_r) || recv_done_i);
    assign recv_drop = !open || (state_r == ICSV_FLUSH);
    assign recv_accept = recv_req_i && (state_r == ICSV_CONNECTED) && !recv_active_r;

    // Every receive request is answered, refused or not
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            recv_resp_valid_o <= 1'b0;
        end else begin
            recv_resp_valid_o <= recv_req_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            recv_resp_o <= RESP_GOOD;
        end else if (recv_req_i) begin
            if (state_r != ICSV_CONNECTED) begin
                recv_resp_o <= RESP_INVALID_CONN;
            end else if (recv_active_r) begin
                recv_resp_o <= RESP_RECV_PENDING;
            end else begin
                recv_resp_o <= RESP_GOOD;
            end
        end
    end

    // A zero maximum is answered but never armed: nothing could be placed
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            recv_active_r <= 1'b0;
        end else if (recv_drop) begin
            recv_active_r <= 1'b0;
        end else if (recv_accept) begin
            recv_active_r <= (recv_max_i != COUNT_RESET);
        end else if (recv_finish) begin
            recv_active_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            recv_max_r <= COUNT_RESET;
        end else if (recv_accept) begin
            recv_max_r <= recv_max_i;
        end
    end

    // Cleared on every start and end, so each receive counts from zero
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            recv_cnt_r <= COUNT_RESET;
        end else if (recv_drop || recv_finish || recv_accept) begin
            recv_cnt_r <= COUNT_RESET;
        end else if (rx_take) begin
            recv_cnt_r <= recv_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            received_ind_o <= 1'b0;
        end else begin
            received_ind_o <= recv_finish && !recv_drop;
        end
    end

    // Count held until the next indication
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            received_count_o <= COUNT_RESET;
        end else if (recv_finish && !recv_drop) begin
            received_count_o <= recv_cnt_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            recv_wr_o <= 1'b0;
        end else begin
            recv_wr_o <= rx_take;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            recv_data_o <= '0;
        end else if (rx_take) begin
            recv_data_o <= rx_data_i;
        end
    end

    // Reset line from the automation device; any rising level reports once
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            peer_reset_prev_r <= 1'b0;
        end else begin
            peer_reset_prev_r <= peer_reset_i;
        end
    end

    // Previous level resets to the idle low, so no false edge after reset
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reset_received_o <= 1'b0;
        end else begin
            reset_received_o <= peer_reset_i && !peer_reset_prev_r;
        end
    end
endmodule

// *** sim/icsv_port_properties.sv ***
// Assertions on the interconnect port top ports.
// Assumes one clock and a synchronous active-high reset.
module icsv_port_properties
    import icsv_pkg::*;
(
    // Clock, reset, pins
    input wire logic clk_i, reset_i, sense_i, peer_reset_i,
    // Requests
    input wire logic connect_req_i, listen_req_i, send_valid_i, recv_req_i,
    input wire logic [icsv_pkg::CNT_W-1:0] recv_max_i,
    // Answers and indications
    input wire logic conn_resp_valid_o, connected_o, connected_ind_o, disconnected_ind_o,
    input wire logic [2:0] conn_resp_o,
    input wire logic [1:0] close_reason_o,
    input wire logic reset_received_o, send_ready_o, send_reject_o, tx_valid_o,
    input wire logic rx_ready_o, recv_wr_o, received_ind_o,
    input wire logic [icsv_pkg::CNT_W-1:0] received_count_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    logic [CNT_W-1:0] max_r;
    logic [CNT_W-1:0] cnt_r;
    // Places since last indication; relies on one receive at a time
    always_ff @(posedge clk_i) begin
        if (reset_i || received_ind_o || disconnected_ind_o) begin
            cnt_r <= '0;
        end else if (recv_wr_o) begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            max_r <= '0;
        end else if (recv_req_i) begin
            max_r <= recv_max_i;
        end
    end
    a_open_answer: assert property (
        (connect_req_i || listen_req_i) |=> conn_resp_valid_o) else $error("open unanswered");
    a_open_at_once: assert property (
        ((connect_req_i || listen_req_i) && sense_i && !connected_o)
        |=> connected_ind_o && connected_o && conn_resp_o == RESP_GOOD)
        else $error("open not immediate");
    a_open_no_phys: assert property (
        ((connect_req_i || listen_req_i) && !sense_i && !connected_o) |=> conn_resp_o == RESP_NO_PHYS && !connected_o)
        else $error("open without sense");
    a_single_conn: assert property (
        ((connect_req_i || listen_req_i) && sense_i && connected_o) |=> conn_resp_o == RESP_PORT_IN_USE
        && !connected_ind_o) else $error("second open");
    a_recv_limit: assert property (
        received_ind_o |-> received_count_o <= max_r && received_count_o == cnt_r) else $error("receive count");
    a_flush_close: assert property (
        (disconnected_ind_o && close_reason_o == CLOSE_REQUESTED) |-> !tx_valid_o && !connected_o)
        else $error("closed with data left");
    a_closed_quiet: assert property (
        (!connected_o && !$past(connected_o)) |-> !recv_wr_o && !rx_ready_o) else $error("receive when closed");
    a_sense_drop: assert property (
        (connected_o && !sense_i) |=> disconnected_ind_o && close_reason_o == CLOSE_SENSE_LOST)
        else $error("sense loss not closed");
    a_send_refuse: assert property (
        (send_valid_i && !connected_o) |-> send_reject_o && !send_ready_o) else $error("send when closed");
    a_reset_pulse: assert property (
        $rose(peer_reset_i) |=> reset_received_o ##1 !reset_received_o) else $error("reset indication");
endmodule

bind icsv_port icsv_port_properties props_u (.*);

// *** sim/icsv_peer.sv ***
// Link partner: sinks sent characters, sources received ones.
// Assumes the bench steers it through its control inputs.
module icsv_peer (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Bench controls
    input wire logic hold_i,
    input wire logic src_en_i,
    input wire logic rst_req_i,
    // Link side
    input wire logic rx_ready_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic peer_reset_o
);
    logic ph_r;
    logic [7:0] seq_r;
    // No exchange on open or close; char held until taken
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ph_r <= 1'b0;
            rx_valid_o <= 1'b0;
            seq_r <= 8'h40;
            peer_reset_o <= 1'b0;
        end else begin
            ph_r <= ~ph_r;
            rx_valid_o <= src_en_i | (rx_valid_o & ~rx_ready_i);
            if (rx_valid_o & rx_ready_i) begin
                seq_r <= seq_r + 8'h01;
            end
            peer_reset_o <= rst_req_i;
        end
    end
    // Slow sink, none while held
    assign tx_ready_o = ph_r & ~hold_i;
    // Idle line shows inverse, never a stale char
    assign rx_data_o = rx_valid_o ? seq_r : ~seq_r;
endmodule

// *** sim/icsv_port_tb.sv ***
// Self-checking bench for the interconnect port.
// Assumes the partner model and checker are compiled first.
module icsv_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import icsv_pkg::*;
    logic clk_i = 0, reset_i = 1, sense_i = 0, peer_reset_i, sense_o, reset_received_o;
    logic connect_req_i = 0, listen_req_i = 0, disconnect_req_i = 0, conn_resp_valid_o;
    logic connected_o, connected_ind_o, disconnected_ind_o, recv_resp_valid_o;
    logic [2:0] conn_resp_o, recv_resp_o;
    logic [1:0] close_reason_o;
    logic send_valid_i = 0, send_ready_o, send_reject_o, tx_valid_o, tx_ready_i;
    logic [7:0] send_data_i = 0, tx_data_o, rx_data_i, recv_data_o, exp_rx = 8'h40;
    logic rx_valid_i, rx_ready_o, recv_req_i = 0, recv_done_i = 0, recv_wr_o, received_ind_o;
    logic [15:0] recv_max_i = 0, received_count_o;
    logic hold = 1, src_en = 0, rst_req = 0;
    logic [7:0] txq[$];
    int mismatches = 0, checks = 0, rxn = 0;
    icsv_port dut_u (.*);
    icsv_peer peer_u (.clk_i, .reset_i, .hold_i(hold), .src_en_i(src_en), .rst_req_i(rst_req),
        .rx_ready_i(rx_ready_o), .tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i),
        .rx_data_o(rx_data_i), .peer_reset_o(peer_reset_i));
    initial forever #50 clk_i = ~clk_i;
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Link tap: sampled at the edge, before updates land
    always @(posedge clk_i) begin
        if (tx_valid_o && tx_ready_i) txq.push_back(tx_data_o);
        if (recv_wr_o) begin
            chk(recv_data_o, exp_rx);
            exp_rx = exp_rx + 8'h01;
            rxn++;
        end
    end
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge clk_i);
        s = 0;
    endtask
    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 300) begin
            @(negedge clk_i);
            n++;
        end
        if (n == 300) begin
            mismatches++;
            $display("MISMATCH t=%0t timeout", $time);
            summarize();
        end
    endtask
    task t_open;
        chk(sense_o, 0);
        send_valid_i = 1;
        pulse(listen_req_i);
        chk(send_reject_o, 1);
        send_valid_i = 0;
        chk(conn_resp_valid_o, 1);
        chk(conn_resp_o, RESP_NO_PHYS);
        sense_i = 1;
        pulse(connect_req_i);
        chk(sense_o, 1);
        chk(conn_resp_o, RESP_GOOD);
        chk(connected_ind_o, 1);
        chk(connected_o, 1);
        pulse(listen_req_i);
        chk(conn_resp_o, RESP_PORT_IN_USE);
        $display("t_open done");
    endtask
    task t_flush;
        int i;
        send_valid_i = 1;
        for (i = 0; i < 20 && send_ready_o; i++) begin
            send_data_i = 8'h10 + i[7:0];
            @(negedge clk_i);
        end
        send_valid_i = 0;
        chk(i[15:0], FIFO_DEPTH[15:0]);
        pulse(disconnect_req_i);
        send_valid_i = 1;
        @(negedge clk_i);
        chk(send_reject_o, 1);
        send_valid_i = 0;
        hold = 0;
        wait_hi(disconnected_ind_o);
        chk(close_reason_o, CLOSE_REQUESTED);
        chk(16'(txq.size()), FIFO_DEPTH[15:0]);
        foreach (txq[k]) chk(txq[k], 8'h10 + k[7:0]);
        $display("t_flush done");
    endtask
    task t_recv;
        int base;
        pulse(listen_req_i);
        chk(conn_resp_o, RESP_GOOD);
        recv_max_i = 16'h0003;
        pulse(recv_req_i);
        chk(recv_resp_o, RESP_GOOD);
        @(negedge clk_i);
        pulse(recv_req_i);
        chk(recv_resp_valid_o, 1);
        chk(recv_resp_o, RESP_RECV_PENDING);
        src_en = 1;
        wait_hi(received_ind_o);
        chk(received_count_o, 16'h0003);
        repeat (3) @(negedge clk_i);
        chk(rxn[15:0], 16'h0003);
        base = rxn;
        recv_max_i = 16'h000a;
        pulse(recv_req_i);
        repeat (2) @(negedge clk_i);
        src_en = 0;
        recv_done_i = 1;
        wait_hi(received_ind_o);
        recv_done_i = 0;
        chk(16'(rxn - base), received_count_o);
        pulse(recv_req_i);
        sense_i = 0;
        @(negedge clk_i);
        chk(disconnected_ind_o, 1);
        chk(close_reason_o, CLOSE_SENSE_LOST);
        @(negedge clk_i);
        base = rxn;
        src_en = 1;
        repeat (8) @(negedge clk_i);
        chk(16'(rxn - base), 16'h0000);
        pulse(recv_req_i);
        chk(recv_resp_o, RESP_INVALID_CONN);
        $display("t_recv done");
    endtask
    task t_reset;
        rst_req = 1;
        wait_hi(reset_received_o);
        @(negedge clk_i);
        chk(reset_received_o, 0);
        rst_req = 0;
        $display("t_reset done");
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        reset_i = 0;
        t_open();
        t_flush();
        t_recv();
        t_reset();
        summarize();
    end
endmodule
